// ==== core/bdm_pkg.sv ====
// package for the banked data memory map: address layout and carriers
package bdm_pkg;

	// ==========================================================
	// address layout
	localparam int BANK_COUNT       = 4;
	localparam int OFFSET_WIDTH     = 7;
	localparam int ADDR_WIDTH       = 9;
	localparam int SFA_SIZE         = 32;
	localparam int RAM_SIZE         = 96;
	localparam logic [6:0] RAM_FIRST    = 7'h20;
	localparam logic [6:0] SHARED_FIRST = 7'h70;
	localparam int SHARED_SIZE      = 16;
	localparam int DEPTH_SMALL      = 128;
	localparam int DEPTH_LARGE      = 256;
	localparam logic [7:0] READ_ZERO    = 8'h00;
	localparam logic [7:0] DATA_RESET   = 8'h00;
	// physical ram index where the own ram of banks 0-2 begins; bank 3 has none
	localparam logic [7:0] BANK0_BASE   = 8'h00;
	localparam logic [7:0] BANK1_BASE   = 8'h60;
	localparam logic [7:0] BANK2_BASE   = 8'hb0;
	// bank select codes
	localparam logic [1:0] BANK0        = 2'h0;
	localparam logic [1:0] BANK1        = 2'h1;
	localparam logic [1:0] BANK2        = 2'h2;
	localparam logic [1:0] BANK3        = 2'h3;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic       wr_en;
		logic       rd_en;
		logic       indirect;
		logic [6:0] offset;
		logic [7:0] wdata;
	} bdm_req_type;

	typedef struct packed {
		logic       valid;
		logic       is_sfa;
		logic       implemented;
		logic [8:0] addr;
		logic [7:0] rdata;
	} bdm_rsp_type;

endpackage

// ==== core/bdm_memory_map.sv ====
// banked data memory map: bank decode, shared window and ram array
`timescale 1ns/10ps
// ==========================================================
// How it works
// - four banks, each special area plus ram
// - lowest 32 offsets of a bank are special
// - upper 96 offsets are ram, variant populated
// - top sixteen of banks 1-3 mirror bank 0
// - unimplemented ram reads back as zero
// - two bank select bits choose the bank of a direct access; indirect uses bank high and pointer bit 7
// - ram depth 128 or 256 bytes, 8 bits
// - direct or indirect pointer reaches every location
// - pull-up only with external reset function
module bdm_memory_map
#(
	parameter int RAM_DEPTH = bdm_pkg::DEPTH_LARGE
)
(
	// clock and reset
	input  wire logic                 clk_sys_i,
	input  wire logic                 rst_b_i,
	// bank select and pointer from the status and pointer registers
	input  wire logic                 bank_select_high_i,
	input  wire logic                 bank_select_low_i,
	input  wire logic [7:0]           indirect_pointer_register_i,
	input  wire logic                 indirect_bank_high_i,
	// configuration and pin pull-up request
	input  wire logic                 external_reset_pin_cfg_i,
	input  wire logic                 pullup_request_i,
	// datapath request and answer
	input  wire bdm_pkg::bdm_req_type req_i,
	output bdm_pkg::bdm_rsp_type      rsp_o,
	// special area access strobe for the register block
	output logic                      sfa_sel_o,
	// weak pull-up enable for the shared reset pin
	output logic                      reset_pin_pullup_o
);
	import bdm_pkg::*;

	// refuse a ram depth that the bank layout cannot serve
	generate
		if (RAM_DEPTH != DEPTH_SMALL && RAM_DEPTH != DEPTH_LARGE)
		begin : g_bad_depth
			$error("ram depth must be 128 or 256");
		end
	endgenerate

	// physical ram index width and synchroniser layout
	localparam int IDX_WIDTH  = $clog2(RAM_DEPTH);
	localparam int SYNC_COUNT = 2;
	localparam int SYNC_CFG   = 0;
	localparam int SYNC_REQ   = 1;

	// ==========================================================
	// address formation
	logic [8:0] addr_next;
	logic [1:0] bank;
	logic [6:0] offs;
	logic       is_sfa;
	logic       is_shared;
	logic       implemented;
	logic [7:0] ram_idx;
	logic [6:0] ram_off;
	logic [IDX_WIDTH-1:0] ram_addr;

	// direct: bank bits over offset; indirect: bank high over pointer
	always_comb
	begin
		if (req_i.indirect)
			addr_next = {indirect_bank_high_i,
				indirect_pointer_register_i};
		else
			addr_next = {bank_select_high_i, bank_select_low_i,
				req_i.offset};
	end

	assign bank = addr_next[ADDR_WIDTH-1:OFFSET_WIDTH];
	assign offs = addr_next[OFFSET_WIDTH-1:0];
	assign is_sfa = (offs < RAM_FIRST);
	assign is_shared = (offs >= SHARED_FIRST);

	// map a ram offset to a physical byte; the shared window folds onto
	// bank 0 so every bank reaches the same sixteen bytes
	always_comb
	begin
		ram_off = offs - RAM_FIRST;
		ram_idx = '0;
		if (is_sfa)
		begin
			ram_idx = '0; // no ram behind the special area
		end
		else if (is_shared)
		begin
			ram_idx = BANK0_BASE + {1'b0, ram_off};
		end
		else if (bank == BANK0)
		begin
			ram_idx = BANK0_BASE + {1'b0, ram_off};
		end
		else if (bank == BANK1)
		begin
			ram_idx = BANK1_BASE + {1'b0, ram_off};
		end
		else if (bank == BANK2)
		begin
			ram_idx = BANK2_BASE + {1'b0, ram_off};
		end
		else
		begin
			ram_idx = '0; // bank 3 keeps only the shared window
		end
	end

	// a byte exists only where a bank has ram and the variant reaches it
	always_comb
	begin
		implemented = 1'b0;
		if (is_sfa)
		begin
			implemented = 1'b0;
		end
		else if (is_shared)
		begin
			implemented = 1'b1;
		end
		else if (bank == BANK3)
		begin
			implemented = 1'b0;
		end
		else
		begin
			implemented = (int'(ram_idx) < RAM_DEPTH);
		end
	end

	// physical address into the array, sized to the variant
	assign ram_addr = ram_idx[IDX_WIDTH-1:0];

	// ==========================================================
	// ram array, 8 bits wide, only as deep as the variant
	logic [7:0] ram_mem [RAM_DEPTH];

	// write an implemented ram byte; special area and holes drop it
	always_ff @(posedge clk_sys_i)
	begin
		if (req_i.wr_en && implemented)
			ram_mem[ram_addr] <= req_i.wdata;
	end

	// ==========================================================
	// registered answer
	// fields refresh every cycle; the datapath trusts them only with valid
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			rsp_o <= '0;
		end
		else
		begin
			rsp_o.valid       <= req_i.rd_en;
			rsp_o.is_sfa      <= is_sfa;
			rsp_o.implemented <= implemented;
			rsp_o.addr        <= addr_next;
			if (req_i.rd_en && implemented)
				rsp_o.rdata <= ram_mem[ram_addr];
			else
				rsp_o.rdata <= READ_ZERO;
		end
	end

	// ==========================================================
	// special area strobe
	// registered one cycle late, high for every cycle that a special area access is requested
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			sfa_sel_o <= 1'b0;
		end
		else
		begin
			sfa_sel_o <= (req_i.rd_en | req_i.wr_en) & is_sfa;
		end
	end

	// ==========================================================
	// reset pin pull-up gate
	wire [SYNC_COUNT-1:0] async_bits;
	wire [SYNC_COUNT-1:0] sync_bits;

	// both inputs come from outside the clock domain
	assign async_bits[SYNC_CFG] = external_reset_pin_cfg_i;
	assign async_bits[SYNC_REQ] = pullup_request_i;

	// two-flop synchroniser per input; only the second flop is read
	generate
		for (genvar gi = 0; gi < SYNC_COUNT; gi++)
		begin : g_sync
			logic meta_reg;
			logic sync_reg;

			always_ff @(posedge clk_sys_i or negedge rst_b_i)
			begin
				if (!rst_b_i)
				begin
					meta_reg <= 1'b0;
					sync_reg <= 1'b0;
				end
				else
				begin
					meta_reg <= async_bits[gi];
					sync_reg <= meta_reg;
				end
			end

			assign sync_bits[gi] = sync_reg;
		end
	endgenerate

	// pull-up only while the pin is configured as external reset
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			reset_pin_pullup_o <= 1'b0;
		end
		else
		begin
			reset_pin_pullup_o <= sync_bits[SYNC_CFG]
				& sync_bits[SYNC_REQ];
		end
	end

endmodule // bdm_memory_map

// ==== tb/bdm_memory_map_sva.sv ====
// port assertions of the memory map
`timescale 1ns/10ps
module bdm_sva
(
	input wire logic clk_sys_i, rst_b_i, reset_pin_pullup_o,
	input wire logic external_reset_pin_cfg_i,
	input wire logic sfa_sel_o,
	input wire bdm_pkg::bdm_req_type req_i,
	input wire bdm_pkg::bdm_rsp_type rsp_o
);
	import bdm_pkg::*;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	property p_v; rsp_o.valid == $past(req_i.rd_en); endproperty
	a_v: assert property (p_v) else $error("valid");
	property p_s; rsp_o.valid |-> rsp_o.is_sfa ==
		(rsp_o.addr[6:0] < RAM_FIRST); endproperty
	a_s: assert property (p_s) else $error("sfa");
	property p_z; rsp_o.valid && !rsp_o.implemented |->
		rsp_o.rdata == READ_ZERO; endproperty
	a_z: assert property (p_z) else $error("zero");
	property p_p; reset_pin_pullup_o |->
		$past(external_reset_pin_cfg_i, 3); endproperty
	a_p: assert property (p_p) else $error("pull");
	property p_sel; sfa_sel_o == (rsp_o.is_sfa &&
		$past(req_i.rd_en || req_i.wr_en)); endproperty
	a_sel: assert property (p_sel) else $error("select");
	property p_sh; rsp_o.valid && rsp_o.addr[6:0] >= SHARED_FIRST |->
		rsp_o.implemented; endproperty
	a_sh: assert property (p_sh) else $error("shared");
	property p_d; rsp_o.valid && !$past(req_i.indirect) |->
		rsp_o.addr[6:0] == $past(req_i.offset); endproperty
	a_d: assert property (p_d) else $error("direct");
endmodule // bdm_sva

// ==== tb/bdm_core_model.sv ====
// datapath model issuing byte accesses
`timescale 1ns/10ps
module bdm_core_model
(
	input wire logic clk_sys_i,
	input wire bdm_pkg::bdm_rsp_type rsp_i,
	output bdm_pkg::bdm_req_type req_o,
	output logic [10:0] ctl_o
);
	import bdm_pkg::*;
	initial {req_o, ctl_o} = '0;
	// one access, unused pointer or bank bits scrambled
	task acc(input logic [31:0] x, input logic w, output bdm_rsp_type r);
		@(negedge clk_sys_i);
		ctl_o = x[20] ? {x[22:21], x[8:0]} : {x[8:7], ~x[8:0]};
		req_o = '{w, !w, x[20], x[20] ? 7'h00 : x[6:0], x[16:9]};
		@(negedge clk_sys_i);
		r = rsp_i;
		req_o = '0;
	endtask
endmodule // bdm_core_model

// ==== tb/testbench.sv ====
// self-checking bench of the memory map
`timescale 1ns/10ps
module testbench;
	import bdm_pkg::*;
	logic clk_sys_i = 1'h0, rst_b_i = 1'h0, pullup_request_i = 1'h0;
	logic external_reset_pin_cfg_i = 1'h0, indirect_bank_high_i;
	logic bank_select_high_i, bank_select_low_i, reset_pin_pullup_o;
	logic [7:0] indirect_pointer_register_i, m [512];
	logic sfa_sel_o;
	logic [10:0] ctl;
	logic [8:0] p;
	logic [1:0] e2;
	logic [31:0] x, s = 32'h00016a7c;
	int err_count = 0, n_compared = 0;
	bdm_req_type req_i;
	bdm_rsp_type rsp_o, r, rsp_small;
	always #5 clk_sys_i = ~clk_sys_i;
	assign {bank_select_high_i, bank_select_low_i, indirect_bank_high_i,
		indirect_pointer_register_i} = ctl;
	bdm_memory_map i_dut (.clk_sys_i, .rst_b_i, .bank_select_high_i,
		.bank_select_low_i, .indirect_pointer_register_i,
		.indirect_bank_high_i, .external_reset_pin_cfg_i,
		.pullup_request_i, .req_i, .rsp_o, .sfa_sel_o,
		.reset_pin_pullup_o);
	// small variant sees the same accesses
	bdm_memory_map #(.RAM_DEPTH(DEPTH_SMALL)) i_dut_small (.clk_sys_i,
		.rst_b_i, .bank_select_high_i, .bank_select_low_i,
		.indirect_pointer_register_i, .indirect_bank_high_i,
		.external_reset_pin_cfg_i, .pullup_request_i, .req_i,
		.rsp_o(rsp_small), .sfa_sel_o(), .reset_pin_pullup_o());
	bdm_core_model i_core (.clk_sys_i, .rsp_i(rsp_o), .req_o(req_i),
		.ctl_o(ctl));
	// ram populated except bank 3 below the shared window
	function automatic logic g(logic [8:0] a);
		return a[6:0] >= RAM_FIRST && (a[8:7] != 2'h3 || a[6:4] == 3'h7);
	endfunction
	// small variant: bank 0, shared window, bank 1 up to 3fh
	function automatic logic gs(logic [8:0] a);
		return a[6:0] >= RAM_FIRST && (a[8:7] == 2'h0 || a[6:4] == 3'h7
			|| (a[8:7] == 2'h1 && a[6:5] == 2'h1));
	endfunction
	function automatic logic [31:0] rnd();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task chk(input logic [8:0] g, e);
		n_compared++;
		if (g !== e)
		begin
			err_count++;
			$display("Error %0t: %h not %h", $time, g, e);
		end
	endtask
	task report_and_stop();
		$display("errors %0d of %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// write every address, read back at random, then pull-up and reset
	initial
	begin
		repeat (20) @(negedge clk_sys_i);
		rst_b_i = 1'h1;
		for (int i = 0; i < 1024; i++)
		begin
			x = rnd();
			if (i < 512)
				x[8:0] = i[8:0];
			i_core.acc(x, i < 512, r);
			p = x[6:0] >= SHARED_FIRST ? {2'h0, x[6:0]} : x[8:0];
			e2 = {x[6:0] < RAM_FIRST, g(x[8:0])};
			chk(sfa_sel_o, x[6:0] < RAM_FIRST);
			chk(r.valid, i > 511);
			if (i < 512 && g(x[8:0]))
				m[p] = x[16:9];
			else if (i > 511)
			begin
				chk(r.addr, x[8:0]);
				chk(r.rdata, g(x[8:0]) ? m[p] : READ_ZERO);
				chk({r.is_sfa, r.implemented}, e2);
				chk(rsp_small.rdata, gs(x[8:0]) ? m[p] : READ_ZERO);
			end
		end
		for (int k = 0; k < 4; k++)
		begin
			{external_reset_pin_cfg_i, pullup_request_i} = k[1:0];
			repeat (4) @(negedge clk_sys_i);
			chk(reset_pin_pullup_o, k == 3);
		end
		rst_b_i = 1'h0;
		@(negedge clk_sys_i);
		chk({reset_pin_pullup_o, rsp_o.valid}, 9'h0);
		report_and_stop();
	end
endmodule // testbench
bind bdm_memory_map bdm_sva i_sva (.clk_sys_i, .rst_b_i,
	.reset_pin_pullup_o, .external_reset_pin_cfg_i, .req_i, .rsp_o,
	.sfa_sel_o);
